/* rtl/pcs_cfg_map.svh */
// Contract
// - coding bit enables NRZI encode and decode
// - select bit picks 2 ms or 722 us
// - disable bit stops descrambler time-out counter
// - repeater carrier: CRS from receive only
// - otherwise CRS from transmit or receive
// - compatibility mode blocks lamp/unlock writes, disables
// - fast-test bit speeds up time-out counter
`ifndef PCS_CFG_MAP_SVH
`define PCS_CFG_MAP_SVH
// register indices (register index space of management bus)
`define PCS_CFG_ADDR        5'h17
`define PCS_CFG_COMPAT_ADDR 5'h1c
// field positions
`define PCS_CFG_B_CODING    15
`define PCS_CFG_B_TO_SEL    14
`define PCS_CFG_B_TO_DIS    13
`define PCS_CFG_B_RPT       12
`define PCS_CFG_B_LAMP      11
`define PCS_CFG_B_UNLOCK    10
`define PCS_CFG_B_FAST      8
`define PCS_CFG_B_COMPAT    0
// reset values
`define PCS_CFG_RST_CODING  1'b1
`define PCS_CFG_RST_TO_SEL  1'b0
`define PCS_CFG_RST_TO_DIS  1'b0
`define PCS_CFG_RST_LAMP    1'b0
`define PCS_CFG_RST_UNLOCK  1'b0
`define PCS_CFG_RST_FAST    1'b0
// times in ns, cycle period in ns
`define PCS_CFG_TO_LONG_NS  2000000
`define PCS_CFG_TO_SHORT_NS 722000
`define PCS_CFG_CLK_NS      5
`define PCS_CFG_FAST_SHIFT  8
`endif

/* rtl/pcs_cfg_pkg.sv */
package pcs_cfg_pkg;
  // strap capture sequencing after reset release
  typedef enum logic [1:0] {
    PCS_STRAP_WAIT = 2'b00,
    PCS_STRAP_TAKE = 2'b01,
    PCS_STRAP_DONE = 2'b10
  } pcs_strap_type;
endpackage

/* rtl/pcs_cfg_if.sv */
`timescale 1ns/100ps
`default_nettype none
// settings passed from the register bank to the helper modules
interface pcs_cfg_if;
  logic coding_en;  // nrzi on
  logic to_sel;     // long time-out
  logic to_dis;     // time-out off
  logic fast;       // fast test
  logic rpt;        // repeater carrier
  modport bank (output coding_en, to_sel, to_dis, fast, rpt);
  modport user (input coding_en, to_sel, to_dis, fast, rpt);
endinterface
`default_nettype wire

/* rtl/pcs_cfg_timeout.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pcs_cfg_map.svh"
// descrambler idle time-out counter
module pcs_cfg_timeout
  import pcs_cfg_pkg::*;
#(
  parameter int LONG_CYC  = `PCS_CFG_TO_LONG_NS / `PCS_CFG_CLK_NS,
  parameter int SHORT_CYC = `PCS_CFG_TO_SHORT_NS / `PCS_CFG_CLK_NS
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  pcs_cfg_if.user   cfg,
  input  wire logic i_idle,     // idle symbol seen
  output logic      o_expired   // pulse on expiry
);
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic [19:0] limit;
  logic        exp_next;
  logic        exp_reg;

  // pick limit, fast test divides it down
  always_comb begin
    limit = cfg.to_sel ? 20'(LONG_CYC) : 20'(SHORT_CYC);
    if (cfg.fast) begin
      limit = limit >> `PCS_CFG_FAST_SHIFT;
    end
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (cfg.to_dis || i_idle) begin
      cnt_next = '0;
    end else if (cnt_reg + 20'h1 >= limit) begin
      cnt_next = '0;
      exp_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 20'h1;
    end
  end

  // register count
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end
  assign o_expired = exp_reg;
endmodule // pcs_cfg_timeout
`default_nettype wire

/* rtl/pcs_cfg_datapath.sv */
`timescale 1ns/100ps
`default_nettype none
// nrzi coder/decoder with bypass, and carrier sense
module pcs_cfg_datapath (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  pcs_cfg_if.user   cfg,
  input  wire logic i_tx_bit,
  input  wire logic i_rx_line,
  input  wire logic i_tx_act,
  input  wire logic i_rx_act,
  output logic      o_tx_line,
  output logic      o_rx_bit,
  output logic      o_crs
);
  logic tx_reg;
  logic tx_next;
  logic rxp_reg;
  logic rxp_next;
  logic rx_reg;
  logic rx_next;
  logic crs_reg;
  logic crs_next;

  // nrzi: a one toggles the line
  always_comb begin
    tx_next  = cfg.coding_en ? (tx_reg ^ i_tx_bit) : i_tx_bit;
    rx_next  = cfg.coding_en ? (i_rx_line ^ rxp_reg) : i_rx_line;
    rxp_next = i_rx_line;
    crs_next = cfg.rpt ? i_rx_act
                       : (i_rx_act | i_tx_act);
  end

  // register line state
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_reg  <= 1'b0;
      rxp_reg <= 1'b0;
      rx_reg  <= 1'b0;
      crs_reg <= 1'b0;
    end else begin
      tx_reg  <= tx_next;
      rxp_reg <= rxp_next;
      rx_reg  <= rx_next;
      crs_reg <= crs_next;
    end
  end
  assign o_tx_line = tx_reg;
  assign o_rx_bit  = rx_reg;
  assign o_crs     = crs_reg;
endmodule // pcs_cfg_datapath
`default_nettype wire

/* rtl/pcs_cfg_top.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_cfg_map.svh"
// pcs sublayer configuration register bank, bits 15..8
module pcs_cfg_top
  import pcs_cfg_pkg::*;
#(
  parameter int LONG_CYC  = `PCS_CFG_TO_LONG_NS / `PCS_CFG_CLK_NS,
  parameter int SHORT_CYC = `PCS_CFG_TO_SHORT_NS / `PCS_CFG_CLK_NS
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // repeater strap
  input  wire logic        i_rpt_strap,
  // data path
  input  wire logic        i_tx_bit,
  input  wire logic        i_rx_line,
  input  wire logic        i_tx_act,
  input  wire logic        i_rx_act,
  input  wire logic        i_idle,
  output logic             o_tx_line,
  output logic             o_rx_bit,
  output logic             o_crs,
  output logic             o_to_expired,
  // lamp and test
  output logic             o_fifth_lamp_source_pick,
  output logic             o_test_unlock
);
  pcs_cfg_if cfg ();

  logic          coding_reg, coding_next;    // nrzi enable
  logic          tosel_reg, tosel_next;      // long time-out
  logic          todis_reg, todis_next;      // time-out off
  logic          rpt_reg, rpt_next;          // repeater carrier
  logic          lamp_reg, lamp_next;        // lamp source
  logic          unlock_reg, unlock_next;    // test unlock
  logic          fast_reg, fast_next;        // fast test
  logic          compat_reg, compat_next;    // compat mode
  logic [15:0]   rdata_reg, rdata_next;      // read data
  logic          lampo_reg, lampo_next;      // lamp output
  logic          unlo_reg, unlo_next;        // unlock output
  pcs_strap_type strap_reg, strap_next;      // strap capture

  // register writes, reads and strap capture
  always_comb begin
    coding_next = coding_reg;
    tosel_next  = tosel_reg;
    todis_next  = todis_reg;
    rpt_next    = rpt_reg;
    lamp_next   = lamp_reg;
    unlock_next = unlock_reg;
    fast_next   = fast_reg;
    compat_next = compat_reg;
    strap_next  = strap_reg;
    rdata_next  = '0;
    // strap sampled on the second clock after release, never under reset
    unique case (strap_reg)
      PCS_STRAP_WAIT: begin
        strap_next = PCS_STRAP_TAKE;
      end
      PCS_STRAP_TAKE: begin
        rpt_next   = i_rpt_strap;
        strap_next = PCS_STRAP_DONE;
      end
      PCS_STRAP_DONE: begin
        strap_next = PCS_STRAP_DONE;
      end
      default: begin
        strap_next = PCS_STRAP_DONE;
      end
    endcase
    if (i_wr && i_addr == `PCS_CFG_ADDR) begin
      coding_next = i_wdata[`PCS_CFG_B_CODING];
      tosel_next  = i_wdata[`PCS_CFG_B_TO_SEL];
      todis_next  = i_wdata[`PCS_CFG_B_TO_DIS];
      rpt_next    = i_wdata[`PCS_CFG_B_RPT];
      // compat mode locks these fields
      if (!compat_reg) begin
        lamp_next   = i_wdata[`PCS_CFG_B_LAMP];
        unlock_next = i_wdata[`PCS_CFG_B_UNLOCK];
        fast_next   = i_wdata[`PCS_CFG_B_FAST];
      end
    end else if (i_wr && i_addr == `PCS_CFG_COMPAT_ADDR) begin
      compat_next = i_wdata[`PCS_CFG_B_COMPAT];
    end
    if (i_rd && i_addr == `PCS_CFG_ADDR) begin
      rdata_next[`PCS_CFG_B_CODING] = coding_reg;
      rdata_next[`PCS_CFG_B_TO_SEL] = tosel_reg;
      rdata_next[`PCS_CFG_B_TO_DIS] = todis_reg;
      rdata_next[`PCS_CFG_B_RPT]    = rpt_reg;
      rdata_next[`PCS_CFG_B_LAMP]   = lamp_reg;
      rdata_next[`PCS_CFG_B_UNLOCK] = unlock_reg;
      rdata_next[`PCS_CFG_B_FAST]   = fast_reg;
    end else if (i_rd && i_addr == `PCS_CFG_COMPAT_ADDR) begin
      rdata_next[`PCS_CFG_B_COMPAT] = compat_reg;
    end
    // disabled fields act as zero in compat mode
    lampo_next = lamp_next & ~compat_next;
    unlo_next  = unlock_next & ~compat_next;
  end

  // registers; strap-dependent bit resets to zero until captured
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      coding_reg <= `PCS_CFG_RST_CODING;
      tosel_reg  <= `PCS_CFG_RST_TO_SEL;
      todis_reg  <= `PCS_CFG_RST_TO_DIS;
      rpt_reg    <= 1'b0;
      lamp_reg   <= `PCS_CFG_RST_LAMP;
      unlock_reg <= `PCS_CFG_RST_UNLOCK;
      fast_reg   <= `PCS_CFG_RST_FAST;
      compat_reg <= 1'b0;
      rdata_reg  <= '0;
      lampo_reg  <= 1'b0;
      unlo_reg   <= 1'b0;
      strap_reg  <= PCS_STRAP_WAIT;
    end else begin
      coding_reg <= coding_next;
      tosel_reg  <= tosel_next;
      todis_reg  <= todis_next;
      rpt_reg    <= rpt_next;
      lamp_reg   <= lamp_next;
      unlock_reg <= unlock_next;
      fast_reg   <= fast_next;
      compat_reg <= compat_next;
      rdata_reg  <= rdata_next;
      lampo_reg  <= lampo_next;
      unlo_reg   <= unlo_next;
      strap_reg  <= strap_next;
    end
  end

  assign cfg.coding_en = coding_reg;
  assign cfg.to_sel    = tosel_reg;
  assign cfg.to_dis    = todis_reg;
  assign cfg.fast      = fast_reg & ~compat_reg;
  assign cfg.rpt       = rpt_reg;

  assign o_rdata                  = rdata_reg;
  assign o_fifth_lamp_source_pick = lampo_reg;
  assign o_test_unlock            = unlo_reg;

  // nrzi and carrier sense
  pcs_cfg_datapath u_dp (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .cfg       (cfg.user),
    .i_tx_bit  (i_tx_bit),
    .i_rx_line (i_rx_line),
    .i_tx_act  (i_tx_act),
    .i_rx_act  (i_rx_act),
    .o_tx_line (o_tx_line),
    .o_rx_bit  (o_rx_bit),
    .o_crs     (o_crs)
  );

  // descrambler idle time-out
  pcs_cfg_timeout #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_to (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .cfg       (cfg.user),
    .i_idle    (i_idle),
    .o_expired (o_to_expired)
  );
endmodule // pcs_cfg_top
`default_nettype wire

/* testbench/pcs_cfg_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// shadows every register write and checks the outputs against it
module pcs_cfg_chk #(
  parameter int LONG_CYC  = 2048,
  parameter int SHORT_CYC = 1024
) (
  // clock, reset and register writes
  input wire logic        i_mclk, i_rst_n, i_wr,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata,
  // data path and lamp/test outputs
  input wire logic        i_tx_bit, i_tx_act, i_rx_act, i_idle,
  input wire logic        o_tx_line, o_crs, o_to_expired,
  input wire logic        i_rx_line, o_rx_bit,
  input wire logic        o_fifth_lamp_source_pick, o_test_unlock
);
  logic [15:0] sh;  // shadow of the config word
  logic        cm;  // compatibility mode
  logic        rv;  // repeater bit known only after a write
  int          cnt; // cycles without idle
  int          lim; // expected time-out in cycles
  always_comb lim = (sh[14] ? LONG_CYC : SHORT_CYC) >> ((sh[8] & ~cm) ? 8 : 0);
  // shadow update; compat keeps bits 11, 10 and 8 as they were
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh <= 16'h8000;
      cm <= 1'b0;
      rv <= 1'b0;
      cnt <= 0;
    end else begin
      cnt <= (i_idle | o_to_expired | sh[13]) ? 0 : cnt + 1;
      if (i_wr && i_addr == 5'h1c) cm <= i_wdata[0];
      if (i_wr && i_addr == 5'h17) begin
        rv <= 1'b1;
        sh <= cm ? {i_wdata[15:12], sh[11:10], 1'b0, sh[8], 8'h00}
                 : i_wdata & 16'hfd00;
      end
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // the release edge itself is skipped: the lines were still held there
  property p_nrzi;
    i_rst_n && sh[15] |=> o_tx_line == ($past(o_tx_line) ^ $past(i_tx_bit));
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi tx wrong");
  property p_plain;
    i_rst_n && !sh[15] |=> o_tx_line == $past(i_tx_bit);
  endproperty
  a_plain: assert property (p_plain) else $error("bypass wrong");
  // decoder needs two line samples taken out of reset
  property p_rx_nrzi;
    i_rst_n && $past(i_rst_n) && sh[15] |=>
      o_rx_bit == ($past(i_rx_line) ^ $past(i_rx_line, 2));
  endproperty
  a_rx_nrzi: assert property (p_rx_nrzi) else $error("rx nrzi bad");
  property p_rx_plain;
    i_rst_n && !sh[15] |=> o_rx_bit == $past(i_rx_line);
  endproperty
  a_rx_plain: assert property (p_rx_plain) else $error("rx bypass");
  property p_crs;
    rv |=> o_crs == $past(sh[12] ? i_rx_act : i_tx_act | i_rx_act);
  endproperty
  a_crs: assert property (p_crs) else $error("crs wrong");
  property p_lamp;
    o_fifth_lamp_source_pick == (sh[11] & ~cm);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp wrong");
  property p_unlock;
    o_test_unlock == (sh[10] & ~cm);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock wrong");
  property p_early;
    o_to_expired |-> cnt >= lim - 2;
  endproperty
  a_early: assert property (p_early) else $error("early expiry");
  property p_late;
    !sh[13] |-> cnt <= lim + 2;
  endproperty
  a_late: assert property (p_late) else $error("late expiry");
  property p_off;
    sh[13] && $past(sh[13]) |-> !o_to_expired;
  endproperty
  a_off: assert property (p_off) else $error("expiry when off");
endmodule // pcs_cfg_chk
bind pcs_cfg_top pcs_cfg_chk #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
  i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr(i_wr),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_tx_bit(i_tx_bit),
  .i_tx_act(i_tx_act), .i_rx_act(i_rx_act), .i_idle(i_idle),
  .o_tx_line(o_tx_line), .o_crs(o_crs), .o_to_expired(o_to_expired),
  .i_rx_line(i_rx_line), .o_rx_bit(o_rx_bit),
  .o_fifth_lamp_source_pick(o_fifth_lamp_source_pick),
  .o_test_unlock(o_test_unlock));
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int LC = 2048; // shortened time-outs
  localparam int SC = 1024;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [4:0]  i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata, d;
  logic        i_rpt_strap = 1'b1, i_tx_bit = 1'b0, i_rx_line = 1'b0;
  logic        i_tx_act = 1'b0, i_rx_act = 1'b0, i_idle = 1'b1, pend = 1'b0;
  logic        o_tx_line, o_rx_bit, o_crs, o_to_expired, o_lamp, o_unlock;
  int          err_total = 0, compares = 0, cycles = 0, gap = 0, l;
  logic [15:0] rq[$]; // expected read data
  int          tq[$]; // expected time-out lengths
  always #2.5 i_mclk = ~i_mclk;
  pcs_cfg_top #(.LONG_CYC(LC), .SHORT_CYC(SC)) i_dut (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rpt_strap(i_rpt_strap),
    .i_tx_bit(i_tx_bit), .i_rx_line(i_rx_line), .i_tx_act(i_tx_act),
    .i_rx_act(i_rx_act), .i_idle(i_idle), .o_tx_line(o_tx_line),
    .o_rx_bit(o_rx_bit), .o_crs(o_crs), .o_to_expired(o_to_expired),
    .o_fifth_lamp_source_pick(o_lamp), .o_test_unlock(o_unlock));
  task automatic wrap_up();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    rq.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask
  // strap is held after release so the bank can capture it
  task automatic rst(input logic s);
    i_rpt_strap <= s;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask
  // drop idle until the first expiry pulse, lim 0 means none wanted
  task automatic expire(input logic [15:0] cfg, input int lim);
    wr(5'h17, cfg);
    @(posedge i_mclk);
    if (lim > 0) tq.push_back(lim);
    i_idle <= 1'b0;
    repeat (LC + 9) begin
      @(posedge i_mclk);
      if (o_to_expired === 1'b1) break;
    end
    i_idle <= 1'b1;
    @(posedge i_mclk);
    chk("pending expiry", 16'(tq.size()), 16'h0000);
  endtask
  // random line traffic keeps coder and carrier busy
  always @(posedge i_mclk)
    {i_tx_bit, i_rx_line, i_tx_act, i_rx_act} <= 4'($urandom);
  // result watcher: read data and expiry spacing
  always @(posedge i_mclk) begin
    cycles++;
    gap <= i_idle ? 0 : gap + 1;
    pend <= i_rd;
    if (pend) chk("rdata", o_rdata, rq.pop_front());
    if (o_to_expired === 1'b1) begin
      if (tq.size() == 0) chk("expiry", 16'h0001, 16'h0000);
      else begin
        l = tq.pop_front();
        chk("gap", {15'h0, gap >= l - 2 && gap <= l + 2}, 16'h1);
      end
    end
    if (cycles > 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(96));
    rst(1'b1);
    rd(5'h17, 16'h9000);
    rd(5'h05, 16'h0000);
    rd(5'h1c, 16'h0000);
    repeat (8) begin
      d = 16'($urandom);
      wr(5'h17, d);
      rd(5'h17, d & 16'hfd00);
    end
    // compat mode blocks lamp, unlock and fast-test writes
    wr(5'h17, 16'h0d00);
    wr(5'h1c, 16'h0001);
    rd(5'h1c, 16'h0001);
    wr(5'h17, 16'h7000);
    wr(5'h1c, 16'h0000);
    rd(5'h17, 16'h7d00);
    expire(16'h8000, SC);
    expire(16'hc000, LC);
    expire(16'h8100, SC >> 8);
    expire(16'hc100, LC >> 8);
    expire(16'ha000, 0);
    rst(1'b0);
    rd(5'h17, 16'h8000);
    repeat (3) @(posedge i_mclk);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
